/* rtl/motor_holding_brake_sequencer.sv */
// motor holding brake sequencer with avalon register slave
//
// How it works
// R01 - brake function 0 disables the brake, 1 enables it, 3 follows link.
// R02 - after the open command the motor holds still for the open delay.
// R03 - a close delay, 0.1 s by default, runs before the motor goes off.
// R04 - the open command shows in status and may drive output 0 or 1.
// R05 - magnetizing lasts the set time; zero with brake on flags an error.
// R06 - an enabled forced-open input opens the brake whatever the state.
// R07 - an enabled forced-close input closes the brake whatever the state.
// R08 - start frequency goes to the slip output; nonzero turns slip on.
// R09 - start frequency comes from the setting or from an external input.
// R10 - start torque comes from zero by default or from an external input.
// R11 - mode 0 to 3 uses start frequency, mode 20 and up uses torque.
// R12 - switch on magnetizes, then opens the brake, waits, then runs.
// R13 - on stop the motor ramps down and below 20 rpm the brake closes.
// R14 - after the close command the motor stays on for the close delay.
// R15 - coast stop or safe torque off closes the brake at once; an active enabled forced-open input keeps it open instead.
// R16 - forced close wins over forced open and over the sequencer.
// R17 - one timer counts both delays and restarts at each brake command.
`timescale 1ns/1ns
module motor_holding_brake_sequencer
  import brake_pkg::*;
#(
  parameter int unsigned TICK_CYC = CYC_PER_MS
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // avalon-mm slave
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // command pins
  input  wire logic        switch_on_i,
  input  wire logic        normal_stop_i,
  input  wire logic        quick_stop_i,
  input  wire logic        coast_stop_i,
  input  wire logic        safe_torque_off_i,
  input  wire logic        forced_open_i,
  input  wire logic        forced_close_i,
  // drive side values
  input  wire logic [15:0] speed_rpm_i,
  input  wire logic        link_brake_i,
  input  wire logic [15:0] ext_start_freq_i,
  input  wire logic [15:0] ext_torque_i,
  // brake and motor outputs
  output logic             brake_open_o,
  output logic             dout0_o,
  output logic             dout1_o,
  output logic             motor_on_o,
  output logic             magnetizing_o,
  output logic             accel_o,
  output logic             ramp_down_o,
  output logic [15:0]      slip_freq_o,
  output logic             slip_comp_en_o,
  output logic [15:0]      torque_set_o,
  output logic             cfg_err_o
);

  // ******************************************************************
  // functions
  // ******************************************************************

  // byte lane merge for register writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ******************************************************************
  // pin synchronisers
  // ******************************************************************
  logic [6:0] pins_s;
  logic       on_s, nstop_s, qstop_s, coast_s, sto_s, fo_s, fc_s;

  brake_sync #(.W(7)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     ({forced_close_i, forced_open_i, safe_torque_off_i,
                 coast_stop_i, quick_stop_i, normal_stop_i, switch_on_i}),
    .sync_o    (pins_s)
  );

  assign {fc_s, fo_s, sto_s, coast_s, qstop_s, nstop_s, on_s} = pins_s;

  // ******************************************************************
  // avalon slave
  // ******************************************************************
  logic [1:0]  fn_q;
  logic        out0_q, out1_q, fo_en_q, fc_en_q, fsrc_q, tsrc_q;
  logic [7:0]  mode_q;
  logic [15:0] mag_q, open_q, close_q, freq_q;
  logic        ack_q;
  logic        wr_ok;
  logic [31:0] ctrl_v, freq_v, stat_v, rd_d;
  logic [31:0] ctrl_w, mag_w, open_w, close_w, freq_w;
  seq_state_t  state_q, state_d;

  assign waitrequest_o = (read_i || write_i) && !ack_q;
  assign wr_ok         = write_i && ack_q;
  assign ctrl_v = {16'h0000, mode_q, 2'h0, fc_en_q, fo_en_q,
                   out1_q, out0_q, fn_q};
  assign freq_v = {15'h0000, fsrc_q, freq_q};
  assign stat_v = {16'h0000, motor_on_o, slip_comp_en_o, cfg_err_o,
                   brake_open_o, 9'h000, state_q};

  // byte lane merged write values
  assign ctrl_w  = be_merge(ctrl_v, writedata_i, byteenable_i);
  assign mag_w   = be_merge({16'h0000, mag_q}, writedata_i, byteenable_i);
  assign open_w  = be_merge({16'h0000, open_q}, writedata_i, byteenable_i);
  assign close_w = be_merge({16'h0000, close_q}, writedata_i, byteenable_i);
  assign freq_w  = be_merge(freq_v, writedata_i, byteenable_i);

  // one wait state on every access
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read_i || write_i) && !ack_q;
    end
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (address_i)
      REG_CTRL:  rd_d = ctrl_v;
      REG_MAG:   rd_d = {16'h0000, mag_q};
      REG_OPEN:  rd_d = {16'h0000, open_q};
      REG_CLOSE: rd_d = {16'h0000, close_q};
      REG_FREQ:  rd_d = freq_v;
      REG_TORQ:  rd_d = {31'h0000_0000, tsrc_q};
      REG_STAT:  rd_d = stat_v;
      default:   rd_d = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && !ack_q) begin
      readdata_o <= rd_d;
    end
  end

  // control register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fn_q    <= FN_OFF; // [R01]
      out0_q  <= 1'b0;
      out1_q  <= 1'b0;
      fo_en_q <= 1'b0; // [R06]
      fc_en_q <= 1'b0; // [R07]
      mode_q  <= MODE_DEF;
    end else if (wr_ok && address_i == REG_CTRL) begin
      fn_q    <= ctrl_w[CTRL_FN_LSB +: 2];
      out0_q  <= ctrl_w[CTRL_OUT0_BIT];
      out1_q  <= ctrl_w[CTRL_OUT1_BIT];
      fo_en_q <= ctrl_w[CTRL_FO_BIT];
      fc_en_q <= ctrl_w[CTRL_FC_BIT];
      mode_q  <= ctrl_w[CTRL_MODE_LSB +: 8];
    end
  end

  // time and start assist registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mag_q   <= MAG_TIME_DEF_MS; // [R05]
      open_q  <= OPEN_DELAY_DEF_MS; // [R02]
      close_q <= CLOSE_DELAY_DEF_MS; // [R03]
      freq_q  <= FREQ_DEF; // [R08]
      fsrc_q  <= 1'b0; // [R09]
      tsrc_q  <= 1'b0; // [R10]
    end else if (wr_ok) begin
      unique case (address_i)
        REG_MAG:   mag_q <= mag_w[15:0];
        REG_OPEN:  open_q <= open_w[15:0];
        REG_CLOSE: close_q <= close_w[15:0];
        REG_FREQ: begin
          freq_q <= freq_w[15:0];
          fsrc_q <= freq_w[FREQ_SRC_BIT];
        end
        REG_TORQ: begin
          if (byteenable_i[0]) begin
            tsrc_q <= writedata_i[TORQ_SRC_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ******************************************************************
  // sequencer
  // ******************************************************************
  logic        brake_en, stop_req, kill, fo_act, fc_act;
  logic        seq_open, cmd_d, tmr_start, tmr_done;
  logic [15:0] tmr_load;

  assign brake_en = (fn_q == FN_ON) || (fn_q == FN_LINK);
  assign stop_req = nstop_s || qstop_s || !on_s;
  assign kill     = coast_s || sto_s;
  assign fo_act   = fo_en_q && fo_s;
  assign fc_act   = fc_en_q && fc_s;

  brake_timer #(.TICK_CYC(TICK_CYC), .W(TIME_W)) u_tmr (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .start_i   (tmr_start),
    .load_i    (tmr_load),
    .done_o    (tmr_done)
  );

  // next state and timer loads
  always_comb begin
    state_d   = state_q;
    tmr_start = 1'b0;
    tmr_load  = mag_q;
    unique case (state_q)
      ST_IDLE: begin
        if (on_s && !stop_req) begin
          state_d   = ST_MAG; // [R12]
          tmr_start = 1'b1; // [R05]
        end
      end
      ST_MAG: begin
        if (stop_req) begin
          state_d = ST_IDLE;
        end else if (tmr_done && brake_en) begin
          state_d   = ST_OPEN; // [R12]
          tmr_start = 1'b1; // [R17]
          tmr_load  = open_q; // [R02]
        end else if (tmr_done) begin
          state_d = ST_RUN;
        end
      end
      ST_OPEN: begin
        if (stop_req) begin
          state_d = ST_RAMP;
        end else if (tmr_done) begin
          state_d = ST_RUN; // [R12]
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          state_d = ST_RAMP; // [R13]
        end
      end
      ST_RAMP: begin
        if (speed_rpm_i < SPEED_CLOSE_RPM && brake_en) begin
          state_d   = ST_CLOSE; // [R13]
          tmr_start = 1'b1; // [R17]
          tmr_load  = close_q; // [R03]
        end else if (speed_rpm_i < SPEED_CLOSE_RPM) begin
          state_d = ST_IDLE;
        end
      end
      ST_CLOSE: begin
        if (tmr_done) begin
          state_d = ST_IDLE; // [R14]
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (kill) begin
      state_d   = ST_IDLE; // [R15]
      tmr_start = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // brake command: forced close, forced open, then sequencer
  always_comb begin
    seq_open = 1'b0;
    if (fn_q == FN_ON) begin
      seq_open = (state_q == ST_OPEN) || (state_q == ST_RUN) ||
                 (state_q == ST_RAMP); // [R01]
    end else if (fn_q == FN_LINK) begin
      seq_open = link_brake_i; // [R01]
    end
    if (fc_act) begin
      cmd_d = 1'b0; // [R16] [R07]
    end else if (fo_act) begin
      cmd_d = 1'b1; // [R06]
    end else begin
      cmd_d = seq_open && !kill; // [R15]
    end
  end

  // registered brake and motor outputs
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      brake_open_o  <= 1'b0;
      dout0_o       <= 1'b0;
      dout1_o       <= 1'b0;
      motor_on_o    <= 1'b0;
      magnetizing_o <= 1'b0;
      accel_o       <= 1'b0;
      ramp_down_o   <= 1'b0;
      cfg_err_o     <= 1'b0;
    end else begin
      brake_open_o  <= cmd_d; // [R04]
      dout0_o       <= out0_q && cmd_d; // [R04]
      dout1_o       <= out1_q && cmd_d; // [R04]
      motor_on_o    <= state_d != ST_IDLE; // [R14]
      magnetizing_o <= state_d == ST_MAG;
      accel_o       <= state_d == ST_RUN;
      ramp_down_o   <= state_d == ST_RAMP;
      cfg_err_o     <= brake_en && mag_q == 16'h0000; // [R05]
    end
  end

  // start assist during the opening phase; slip enable follows a nonzero start frequency in every state
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      slip_freq_o    <= 16'h0000;
      slip_comp_en_o <= 1'b0;
      torque_set_o   <= 16'h0000;
    end else begin
      slip_comp_en_o <= freq_q != 16'h0000; // [R08]
      slip_freq_o    <= 16'h0000;
      torque_set_o   <= 16'h0000;
      if (state_d == ST_OPEN && mode_q <= MODE_VF_MAX) begin
        slip_freq_o <= fsrc_q ? ext_start_freq_i : freq_q; // [R09] [R11]
      end
      if (state_d == ST_OPEN && mode_q >= MODE_VEC_MIN && tsrc_q) begin
        torque_set_o <= ext_torque_i; // [R10] [R11]
      end
    end
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_mode_off: assert property (fn_q == FN_OFF && !fo_act |=> // [R01]
    !brake_open_o) else $error("brake opened while disabled");
  a_open_hold: assert property (state_q == ST_OPEN && !tmr_done && // [R02]
    !stop_req && !kill |=> state_q == ST_OPEN && !accel_o)
    else $error("left open wait early");
  a_close_wait: assert property (state_q == ST_CLOSE && !tmr_done && // [R03]
    !kill |=> state_q == ST_CLOSE && motor_on_o)
    else $error("motor off before close delay");
  a_dout_route: assert property (dout0_o == // [R04]
    (brake_open_o && $past(out0_q))) else $error("output 0 misrouted");
  a_mag_cfg: assert property (brake_en && mag_q == 16'h0000 |=> // [R05]
    cfg_err_o) else $error("zero magnetize not flagged");
  a_force_open: assert property (fo_act && !fc_act |=> // [R06]
    brake_open_o) else $error("forced open ignored");
  a_close_prio: assert property (fc_act |=> !brake_open_o && // [R16]
    !dout0_o && !dout1_o) else $error("forced close lost");
  a_slip_auto: assert property (freq_q != 16'h0000 |=> // [R08]
    slip_comp_en_o) else $error("slip not switched on");
  a_torque_zero: assert property (!$past(tsrc_q) |-> // [R10]
    torque_set_o == 16'h0000) else $error("torque without source");
  a_assist_mode: assert property (slip_freq_o != 16'h0000 |-> // [R11]
    $past(mode_q) <= MODE_VF_MAX) else $error("slip freq in vector mode");
  a_open_after: assert property (state_q == ST_MAG && tmr_done && // [R12]
    brake_en && !stop_req && !kill |=> state_q == ST_OPEN ##1
    (brake_open_o || fc_act || fn_q != FN_ON))
    else $error("no open after magnetize");
  a_speed_close: assert property (state_q == ST_RAMP && brake_en && // [R13]
    speed_rpm_i < SPEED_CLOSE_RPM && !kill |=> state_q == ST_CLOSE)
    else $error("brake not closed below speed");
  a_close_after: assert property (state_q == ST_CLOSE && tmr_done && // [R14]
    !kill |=> state_q == ST_IDLE && !motor_on_o)
    else $error("motor not off after close delay");
  a_kill_close: assert property (kill && !fo_act |=> // [R15]
    !brake_open_o && state_q == ST_IDLE) else $error("coast kept brake");
  a_timer_rst: assert property ($changed(state_q) && // [R17]
    (state_q == ST_OPEN || state_q == ST_CLOSE) |-> $past(tmr_start))
    else $error("timer not restarted");

  c_reach_run: cover property (state_q == ST_OPEN ##1 state_q == ST_RUN);
  c_close_idle: cover property (state_q == ST_CLOSE ##1 state_q == ST_IDLE);
  c_force_open: cover property (fo_act && state_q == ST_IDLE);
  c_coast_run: cover property (state_q == ST_RUN && kill);

endmodule

/* rtl/brake_pkg.sv */
// constants, register map and states of the motor holding brake sequencer
package brake_pkg;

  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned TIME_W        = 16;
  localparam logic [15:0] MAG_TIME_DEF_MS   = 16'h0000; // 0 s
  localparam logic [15:0] OPEN_DELAY_DEF_MS = 16'h0064; // 0.1 s
  localparam logic [15:0] CLOSE_DELAY_DEF_MS = 16'h0064; // 0.1 s
  localparam logic [15:0] SPEED_CLOSE_RPM   = 16'h0014; // 20 rpm

  // ******************************************************************
  // register map, byte addresses
  // ******************************************************************
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_MAG   = 5'h04;
  localparam logic [4:0] REG_OPEN  = 5'h08;
  localparam logic [4:0] REG_CLOSE = 5'h0C;
  localparam logic [4:0] REG_FREQ  = 5'h10;
  localparam logic [4:0] REG_TORQ  = 5'h14;
  localparam logic [4:0] REG_STAT  = 5'h18;

  // control register fields and reset values
  localparam int unsigned CTRL_FN_LSB   = 0;
  localparam int unsigned CTRL_OUT0_BIT = 2;
  localparam int unsigned CTRL_OUT1_BIT = 3;
  localparam int unsigned CTRL_FO_BIT   = 4;
  localparam int unsigned CTRL_FC_BIT   = 5;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam logic [1:0] FN_OFF  = 2'h0;
  localparam logic [1:0] FN_ON   = 2'h1;
  localparam logic [1:0] FN_LINK = 2'h3;
  localparam logic [7:0] MODE_DEF    = 8'h00;
  localparam logic [7:0] MODE_VF_MAX = 8'h03;
  localparam logic [7:0] MODE_VEC_MIN = 8'h14; // 20
  localparam logic [15:0] FREQ_DEF   = 16'h0000; // 0 %
  localparam int unsigned FREQ_SRC_BIT = 16;
  localparam int unsigned TORQ_SRC_BIT = 0;

  // status register fields
  localparam int unsigned STAT_CMD_BIT   = 12;
  localparam int unsigned STAT_CFG_BIT   = 13;
  localparam int unsigned STAT_SLIP_BIT  = 14;
  localparam int unsigned STAT_MOTOR_BIT = 15;

  // ******************************************************************
  // sequencer states
  // ******************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_MAG   = 3'h1,
    ST_OPEN  = 3'h2,
    ST_RUN   = 3'h3,
    ST_RAMP  = 3'h4,
    ST_CLOSE = 3'h5
  } seq_state_t;

endpackage

/* rtl/brake_sync.sv */
// two flop synchroniser for the command pins
`timescale 1ns/1ns
module brake_sync #(
  parameter int unsigned W = 7
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // pins and synchronised levels
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // first flop feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule

/* rtl/brake_timer.sv */
// millisecond delay timer, restarted on each load
`timescale 1ns/1ns
module brake_timer #(
  parameter int unsigned TICK_CYC = 100000,
  parameter int unsigned W        = 16
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // control
  input  wire logic         start_i,
  input  wire logic [W-1:0] load_i,
  output logic              done_o
);

  localparam int unsigned PW = $clog2(TICK_CYC + 1);

  logic [PW-1:0] pre_q;
  logic [W-1:0]  left_q;
  logic          run_q;

  // prescaler to ms ticks, then count down
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pre_q  <= '0;
      left_q <= '0;
      run_q  <= 1'b0;
    end else if (start_i) begin
      pre_q  <= '0;
      left_q <= load_i;
      run_q  <= 1'b1;
    end else if (run_q && left_q != '0) begin
      if (pre_q == PW'(TICK_CYC - 1)) begin
        pre_q  <= '0;
        left_q <= left_q - W'(1);
      end else begin
        pre_q <= pre_q + PW'(1);
      end
    end
  end

  assign done_o = run_q && (left_q == '0);

endmodule

/* tb/brake_relay_model.sv */
// relay and brake model driven by the brake output pins
`timescale 1ns/1ns
module brake_relay_model #(
  parameter int unsigned RUN_CYC = 6
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  // relay coil and brake state
  input  wire logic coil_i,
  output logic      released_o
);
  int unsigned cnt_q;

  // counts relay run time while coil and brake disagree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i || coil_i == released_o) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end

  // brake moves only once the run time has passed
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      released_o <= 1'b0;
    end else if (cnt_q == RUN_CYC - 1) begin
      released_o <= coil_i;
    end
  end
endmodule

/* tb/test_motor_holding_brake_sequencer.sv */
// self-checking bench for the motor holding brake sequencer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end
module test_motor_holding_brake_sequencer;
  import brake_pkg::*;
  localparam int TK   = 4;
  localparam int MAGT = 2;
  localparam int OPT  = 3;
  localparam int CLT  = 3;
  logic        clk_sys_i, rst_b_i, read_i, write_i, waitrequest_o;
  logic        switch_on_i, normal_stop_i, quick_stop_i, coast_stop_i;
  logic        safe_torque_off_i, forced_open_i, forced_close_i;
  logic        link_brake_i, brake_open_o, dout0_o, dout1_o, motor_on_o;
  logic        magnetizing_o, accel_o, ramp_down_o, slip_comp_en_o;
  logic        cfg_err_o, released;
  logic [3:0]  byteenable_i;
  logic [4:0]  address_i;
  logic [15:0] speed_rpm_i, ext_start_freq_i, ext_torque_i, slip_freq_o;
  logic [15:0] torque_set_o, freq;
  logic [31:0] writedata_i, readdata_o, rd;
  int          fail_count, comparisons, seed, n;
  logic [31:0] rst_tab [8] = '{32'h0, 32'h0, 32'h64, 32'h64, 32'h0,
                               32'h0, 32'h0, 32'h0};

  motor_holding_brake_sequencer #(.TICK_CYC(TK)) dut (
    .clk_sys_i, .rst_b_i, .address_i, .read_i, .write_i, .byteenable_i,
    .writedata_i, .readdata_o, .waitrequest_o, .switch_on_i,
    .normal_stop_i, .quick_stop_i, .coast_stop_i, .safe_torque_off_i,
    .forced_open_i, .forced_close_i, .speed_rpm_i, .link_brake_i,
    .ext_start_freq_i, .ext_torque_i, .brake_open_o, .dout0_o, .dout1_o,
    .motor_on_o, .magnetizing_o, .accel_o, .ramp_down_o, .slip_freq_o,
    .slip_comp_en_o, .torque_set_o, .cfg_err_o
  );

  brake_relay_model #(.RUN_CYC(6)) relay (
    .clk_sys_i, .rst_b_i, .coil_i(dout0_o | dout1_o), .released_o(released)
  );

  // free running system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int t;
    t = 0;
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clk_sys_i);
      t++;
    end while (waitrequest_o !== 1'b0);
    `CHK("bus_wait", 2, t);
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // waits for a level, edges counted in n
  task automatic wait_lv(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask

  function automatic logic in_rng(input int x, input int lo, input int hi);
    return x >= lo && x <= hi;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    fail_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    seed = 32'hC5B3;
    {rst_b_i, read_i, write_i, switch_on_i, normal_stop_i} = 5'h0;
    {quick_stop_i, coast_stop_i, safe_torque_off_i} = 3'h0;
    {forced_open_i, forced_close_i, link_brake_i} = 3'h0;
    {address_i, byteenable_i, writedata_i} = 41'h0;
    {speed_rpm_i, ext_start_freq_i, ext_torque_i} = 48'h0;
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0, 4'hF);
      `CHK("reset_value", rst_tab[i], rd);
    end
    bus(1'b1, REG_STAT, 32'hFFFF_FFFF, 4'hF);
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, REG_STAT, 32'h0, 4'hF);
    `CHK("stat_ro", 32'h0, rd);
    bus(1'b1, REG_OPEN, 32'h0000_1234, 4'h1);
    bus(1'b0, REG_OPEN, 32'h0, 4'hF);
    `CHK("lane_write", 32'h34, rd);
    bus(1'b1, REG_CTRL, {30'h0, FN_ON}, 4'hF);
    repeat (3) @(posedge clk_sys_i);
    `CHK("cfg_err", 1'b1, cfg_err_o);
    bus(1'b1, REG_MAG, MAGT, 4'hF);
    bus(1'b1, REG_OPEN, OPT, 4'hF);
    bus(1'b1, REG_CLOSE, CLT, 4'hF);
    for (int k = 0; k < 4; k++) begin
      freq = 16'($random(seed)) | 16'h0001;
      ext_start_freq_i <= 16'($random(seed));
      ext_torque_i <= 16'($random(seed));
      bus(1'b1, REG_FREQ, {15'h0, k == 2, freq}, 4'hF);
      bus(1'b1, REG_TORQ, 32'h1, 4'hF);
      bus(1'b1, REG_CTRL, {16'h0, (k == 1) ? MODE_VEC_MIN : MODE_DEF,
          4'h0, k[0], !k[0], FN_ON}, 4'hF);
      switch_on_i <= 1'b1;
      wait_lv(magnetizing_o, 1'b1);
      `CHK("brake_in_mag", 1'b0, brake_open_o);
      wait_lv(brake_open_o, 1'b1);
      `CHK("mag_time", 1'b1, in_rng(n, MAGT*TK, MAGT*TK+3));
      @(posedge clk_sys_i);
      `CHK("accel_in_open", 1'b0, accel_o);
      `CHK("slip_freq", (k == 1) ? 16'h0 : (k == 2) ? ext_start_freq_i : freq,
           slip_freq_o);
      `CHK("slip_en", 1'b1, slip_comp_en_o);
      `CHK("torque", (k == 1) ? ext_torque_i : 16'h0, torque_set_o);
      wait_lv(accel_o, 1'b1);
      `CHK("open_time", 1'b1, in_rng(n, OPT*TK-1, OPT*TK+3));
      `CHK("relay_open", 1'b1, released);
      `CHK("dout0_sel", !k[0], dout0_o);
      `CHK("dout1_sel", k[0], dout1_o);
      bus(1'b0, REG_STAT, 32'h0, 4'hF);
      `CHK("stat_open", 1'b1, rd[STAT_CMD_BIT]);
      speed_rpm_i <= (k == 0) ? SPEED_CLOSE_RPM :
                     16'h0015 + 16'($random(seed) & 32'h1FF);
      normal_stop_i <= (k == 0);
      quick_stop_i <= (k == 1);
      coast_stop_i <= (k == 2);
      safe_torque_off_i <= (k == 3);
      if (k < 2) begin
        wait_lv(ramp_down_o, 1'b1);
        repeat (10) @(posedge clk_sys_i);
        `CHK("open_above", 1'b1, brake_open_o);
        speed_rpm_i <= SPEED_CLOSE_RPM - 16'h0001;
      end
      wait_lv(brake_open_o, 1'b0);
      `CHK("close_lag", 1'b1, in_rng(n, 0, 5));
      if (k < 2) begin
        `CHK("motor_held", 1'b1, motor_on_o);
        wait_lv(motor_on_o, 1'b0);
        `CHK("close_time", 1'b1, in_rng(n, CLT*TK-1, CLT*TK+3));
      end
      {normal_stop_i, quick_stop_i, coast_stop_i, safe_torque_off_i} <= 4'h0;
      switch_on_i <= 1'b0;
      speed_rpm_i <= 16'h0000;
      wait_lv(motor_on_o, 1'b0);
      repeat (4) @(posedge clk_sys_i);
    end
    forced_open_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    `CHK("fo_disabled", 1'b0, brake_open_o);
    bus(1'b1, REG_CTRL, 32'h0000_0031, 4'hF);
    wait_lv(brake_open_o, 1'b1);
    `CHK("forced_open", 1'b1, in_rng(n, 1, 5));
    forced_close_i <= 1'b1;
    wait_lv(brake_open_o, 1'b0);
    `CHK("forced_close", 1'b1, in_rng(n, 1, 5));
    {forced_open_i, forced_close_i} <= 2'h0;
    for (int f = 0; f < 2; f++) begin
      bus(1'b1, REG_CTRL, f ? {30'h0, FN_LINK} : 32'h0, 4'hF);
      link_brake_i <= 1'b1;
      switch_on_i <= 1'b1;
      wait_lv(accel_o, 1'b1);
      `CHK("fn_brake", f[0], brake_open_o);
      `CHK("fn_cfg_err", 1'b0, cfg_err_o);
      link_brake_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      `CHK("link_follow", 1'b0, brake_open_o);
      switch_on_i <= 1'b0;
      wait_lv(motor_on_o, 1'b0);
    end
    wrap_up();
  end
endmodule
